// ===== pkg/sfic_pkg.sv
// Shared constants, register map and config layout of the fault conditioning
package sfic_pkg;
    // ==========================================================
    // Channel counts
    localparam int NUM_PRIMARY = 5;
    localparam int NUM_DUAL = 5;
    localparam int NUM_CHAN = NUM_PRIMARY + NUM_DUAL;
    localparam int NUM_FILT = NUM_CHAN + NUM_DUAL;
    localparam int CODE_W = 8;
    localparam int HYST_W = 5;
    localparam int US_W = 7;
    localparam int CNT_W = 12;

    // ==========================================================
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int GLITCH_MAX_US = 100;
    localparam int PULSE_MAX_US = 100;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam logic [US_W-1:0] US_LIMIT = 7'h64;
    localparam logic [CNT_W-1:0] CYC_US = 12'h028;

    // ==========================================================
    // Register map, byte addresses
    localparam logic [7:0] CHAN_CFG_BASE = 8'h00;
    localparam logic [7:0] DUAL_CFG_BASE = 8'h28;
    localparam logic [7:0] STATUS_ADDR = 8'h40;
    localparam logic [7:0] RAW_ADDR = 8'h44;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ==========================================================
    // Fault selection, bit 0 undervoltage, bit 1 excess voltage
    typedef enum logic [1:0] {
        SFIC_SEL_OFF = 2'h0,
        SFIC_SEL_UV = 2'h1,
        SFIC_SEL_OV = 2'h2,
        SFIC_SEL_WINDOW = 2'h3
    } sfic_sel_t;

    // Per detector configuration, one register word
    typedef struct packed {
        logic [US_W-1:0] glitch_us;
        logic [1:0] range;
        sfic_sel_t sel;
        logic [HYST_W-1:0] hysteresis_code;
        logic [CODE_W-1:0] ov_th;
        logic [CODE_W-1:0] uv_th;
    } sfic_chan_cfg_t;

    // Dual function input configuration, one register word
    typedef struct packed {
        logic [US_W-1:0] pulse_us;
        logic pull_down;
        logic edge_mode;
        logic digital;
    } sfic_dual_cfg_t;

    localparam sfic_chan_cfg_t CHAN_CFG_RESET = '0;
    localparam sfic_dual_cfg_t DUAL_CFG_RESET = '0;
endpackage

// ===== core/sfic_core.sv
// Supply fault input conditioning: hysteresis, glitch filters, digital inputs
//
// Functional notes
// - Undervoltage holds until above threshold plus hysteresis
// - Excess voltage holds until below threshold minus hysteresis
// - In tolerance, compare against the bare threshold
// - Hysteresis code is five bits, threshold steps
// - Every detector output has a final glitch filter
// - Pulses shorter than timeout never reach output
// - Longer pulses pass, lagging exactly the timeout
// - Dual input analog mode has single range
// - Digital mode moves detector onto mapped primary input
// - Secondary detector shares range, reports warning
// - Warnings readable and ORed to sequencer
// - Digital inputs delivered to sequencer as inputs
// - Level mode outputs buffered pin level
// - Edge mode emits programmable width pulse
// - Digital inputs use the same glitch filter
// - Weak pull-down only when selected, digital mode
// - Thresholds are eight bit codes per detector
// - Analog and digital use of input exclusive
`timescale 1ns/1ps
module sfic_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Comparator front end level codes, one per channel; warning detectors reuse the primary codes
    input wire logic [sfic_pkg::NUM_CHAN-1:0][sfic_pkg::CODE_W-1:0] level,
    // Dual function pins as logic inputs, asynchronous
    input wire logic [sfic_pkg::NUM_DUAL-1:0] dual_function_input,
    // Towards the sequencing engine
    output logic [sfic_pkg::NUM_CHAN-1:0] fault,
    output logic warning_any,
    output logic [sfic_pkg::NUM_DUAL-1:0] digital_out,
    // Weak pull-down enables of the dual function pins
    output logic [sfic_pkg::NUM_DUAL-1:0] pull_down_en
);
    localparam int NC = sfic_pkg::NUM_CHAN;
    localparam int ND = sfic_pkg::NUM_DUAL;
    localparam int NP = sfic_pkg::NUM_PRIMARY;
    localparam int NF = sfic_pkg::NUM_FILT;
    localparam int CW = sfic_pkg::CNT_W;

    // ==========================================================
    // Helper functions
    // Clamp a microsecond field to the documented maximum
    function automatic logic [sfic_pkg::US_W-1:0] clamp_us(
        input logic [sfic_pkg::US_W-1:0] us
    );
        clamp_us = (us > sfic_pkg::US_LIMIT) ? sfic_pkg::US_LIMIT : us;
    endfunction

    // Microseconds to clock cycles, at most 4000 so it fits twelve bits
    function automatic logic [CW-1:0] us_to_cyc(
        input logic [sfic_pkg::US_W-1:0] us
    );
        logic [2*CW-1:0] prod;
        prod = {{(2*CW-sfic_pkg::US_W){1'b0}}, us} *
               {{CW{1'b0}}, sfic_pkg::CYC_US};
        us_to_cyc = prod[CW-1:0];
    endfunction

    // Undervoltage flag with hysteresis on release only
    function automatic logic uv_next(
        input logic flag,
        input logic [sfic_pkg::CODE_W-1:0] lvl,
        input sfic_pkg::sfic_chan_cfg_t c
    );
        logic [sfic_pkg::CODE_W:0] release_at;
        release_at = {1'b0, c.uv_th} + {4'h0, c.hysteresis_code};
        if (!flag) begin
            uv_next = lvl < c.uv_th;
        end else begin
            uv_next = !({1'b0, lvl} > release_at);
        end
    endfunction

    // Excess voltage flag; adding to the level avoids an underflow
    function automatic logic ov_next(
        input logic flag,
        input logic [sfic_pkg::CODE_W-1:0] lvl,
        input sfic_pkg::sfic_chan_cfg_t c
    );
        logic [sfic_pkg::CODE_W:0] lvl_plus;
        lvl_plus = {1'b0, lvl} + {4'h0, c.hysteresis_code};
        if (!flag) begin
            ov_next = lvl > c.ov_th;
        end else begin
            ov_next = !(lvl_plus < {1'b0, c.ov_th});
        end
    endfunction

    // ==========================================================
    // Configuration storage
    sfic_pkg::sfic_chan_cfg_t chan_cfg [NC];
    sfic_pkg::sfic_dual_cfg_t dual_cfg [ND];

    // Bus decode
    wire logic [5:0] word_idx = address[7:2];
    wire logic chan_hit = word_idx < 6'(NC);
    wire logic dual_hit = (word_idx >= 6'(NC)) && (word_idx < 6'(NC + ND));
    wire logic [3:0] chan_idx = word_idx[3:0];
    wire logic [2:0] dual_idx = 3'(word_idx - 6'(NC));
    wire logic bus_take = write && !waitrequest;

    // Write data shaped for storage
    sfic_pkg::sfic_chan_cfg_t wr_chan;
    sfic_pkg::sfic_dual_cfg_t wr_dual;
    always_comb begin
        wr_chan = sfic_pkg::sfic_chan_cfg_t'(writedata[$bits(wr_chan)-1:0]);
        wr_chan.glitch_us = clamp_us(wr_chan.glitch_us);
        if (chan_idx >= 4'(NP)) begin
            wr_chan.range = 2'h0;
        end
        wr_dual = sfic_pkg::sfic_dual_cfg_t'(writedata[$bits(wr_dual)-1:0]);
        wr_dual.pulse_us = clamp_us(wr_dual.pulse_us);
    end

    // Register writes take effect at the edge that ends the waitrequest low cycle
    always_ff @(posedge core_clk) begin
        for (int k = 0; k < NC; k++) begin
            if (rst) begin
                chan_cfg[k] <= sfic_pkg::CHAN_CFG_RESET;
            end else if (bus_take && chan_hit && chan_idx == 4'(k)) begin
                chan_cfg[k] <= wr_chan;
            end
        end
        for (int k = 0; k < ND; k++) begin
            if (rst) begin
                dual_cfg[k] <= sfic_pkg::DUAL_CFG_RESET;
            end else if (bus_take && dual_hit && dual_idx == 3'(k)) begin
                dual_cfg[k] <= wr_dual;
            end
        end
    end

    // ==========================================================
    // Pin synchronisers; stage one is read by stage two only
    logic [ND-1:0] pin_meta;
    logic [ND-1:0] pin_sync;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= dual_function_input;
            pin_sync <= pin_meta;
        end
    end

    // ==========================================================
    // Hysteresis comparators: 0-4 primary, 5-9 dual analog, 10-14 warning
    logic [NF-1:0] uv_flag;
    logic [NF-1:0] ov_flag;
    logic [NF-1:0] filt_in;
    logic [NF-1:0] filt_out;

    genvar g;
    generate
        for (g = 0; g < NF; g++) begin : g_det
            localparam int CI = (g < NC) ? g : g - ND;
            localparam int LI = (g < NC) ? g : g - NC;
            localparam int DI = (g < NP) ? 0 : ((g < NC) ? g - NP : g - NC);
            // Warning detectors watch the mapped primary level
            wire sfic_pkg::sfic_chan_cfg_t c = chan_cfg[CI];
            wire logic dig = (g >= NP) && dual_cfg[DI].digital;
            wire logic active = (g < NP) ? 1'b1 :
                                ((g < NC) ? !dig : dig);
            wire logic uv_en = c.sel[0] && active;
            wire logic ov_en = c.sel[1] && active;
            wire logic uv_n = uv_en && uv_next(uv_flag[g], level[LI], c);
            wire logic ov_n = ov_en && ov_next(ov_flag[g], level[LI], c);

            // Flags restart from in-tolerance whenever disabled
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    uv_flag[g] <= 1'b0;
                    ov_flag[g] <= 1'b0;
                end else begin
                    uv_flag[g] <= uv_n;
                    ov_flag[g] <= ov_n;
                end
            end

            // Dual inputs in digital mode feed the pin through the filter
            if (g >= NP && g < NC) begin : g_dual_src
                assign filt_in[g] = dig ? pin_sync[DI] :
                                    (uv_flag[g] | ov_flag[g]);
            end else begin : g_ana_src
                assign filt_in[g] = uv_flag[g] | ov_flag[g];
            end

            // Glitch filter; limit 0 still costs the one register stage
            logic [CW-1:0] cnt;
            wire logic [CW-1:0] limit = us_to_cyc(c.glitch_us);
            wire logic [CW:0] cnt_inc = {1'b0, cnt} + 13'h0001;
            wire logic expire = cnt_inc >= {1'b0, limit};
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    cnt <= '0;
                    filt_out[g] <= 1'b0;
                end else if (filt_in[g] == filt_out[g]) begin
                    cnt <= '0;
                end else if (expire) begin
                    cnt <= '0;
                    filt_out[g] <= filt_in[g];
                end else begin
                    cnt <= cnt_inc[CW-1:0];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Digital input blocks: level copy or edge pulse
    logic [ND-1:0] dig_prev;
    logic [ND-1:0] dig_pulse;
    logic [ND-1:0][CW-1:0] pulse_cnt;
    generate
        for (g = 0; g < ND; g++) begin : g_dig
            wire logic d = filt_out[NP + g];
            wire logic edge_seen = d != dig_prev[g];
            wire logic [CW-1:0] width = us_to_cyc(dual_cfg[g].pulse_us);
            // Width zero still yields a single cycle pulse
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    dig_prev[g] <= 1'b0;
                    dig_pulse[g] <= 1'b0;
                    pulse_cnt[g] <= '0;
                end else begin
                    dig_prev[g] <= d;
                    if (edge_seen) begin
                        dig_pulse[g] <= 1'b1;
                        pulse_cnt[g] <= (width > 12'h001) ?
                                        width - 12'h001 : 12'h000;
                    end else if (pulse_cnt[g] != 12'h000) begin
                        pulse_cnt[g] <= pulse_cnt[g] - 12'h001;
                    end else begin
                        dig_pulse[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Outputs to the sequencing engine and pin pull-downs, all registered
    logic [ND-1:0] dig_sel;
    logic [ND-1:0] edge_sel;
    logic [ND-1:0] pd_sel;
    always_comb begin
        for (int k = 0; k < ND; k++) begin
            dig_sel[k] = dual_cfg[k].digital;
            edge_sel[k] = dual_cfg[k].edge_mode;
            pd_sel[k] = dual_cfg[k].pull_down;
        end
    end
    wire logic [ND-1:0] warn_vec = filt_out[NF-1:NC] & dig_sel;
    wire logic [ND-1:0] lvl_copy = filt_out[NC-1:NP];
    wire logic [ND-1:0] next_digital_out =
        dig_sel & ((edge_sel & dig_pulse) | (~edge_sel & lvl_copy));
    wire logic [NC-1:0] next_fault =
        {filt_out[NC-1:NP] & ~dig_sel, filt_out[NP-1:0]};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fault <= '0;
            warning_any <= 1'b0;
            digital_out <= '0;
            pull_down_en <= '0;
        end else begin
            fault <= next_fault;
            warning_any <= |warn_vec;
            digital_out <= next_digital_out;
            pull_down_en <= dig_sel & pd_sel;
        end
    end

    // ==========================================================
    // Read multiplexer
    wire logic [31:0] status_word = {11'h000, warning_any, warn_vec,
                                     digital_out, fault};
    wire logic [31:0] raw_word = {2'h0, ov_flag, uv_flag};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = sfic_pkg::READ_ZERO;
        if (chan_hit) begin
            rd_mux[$bits(sfic_pkg::sfic_chan_cfg_t)-1:0] = chan_cfg[chan_idx];
        end else if (dual_hit) begin
            rd_mux[$bits(sfic_pkg::sfic_dual_cfg_t)-1:0] = dual_cfg[dual_idx];
        end else if (address == sfic_pkg::STATUS_ADDR) begin
            rd_mux = status_word;
        end else if (address == sfic_pkg::RAW_ADDR) begin
            rd_mux = raw_word;
        end
    end

    // ==========================================================
    // Avalon handshake: one wait cycle, then a single low cycle
    // The extra cycle keeps readdata and waitrequest registered
    always_ff @(posedge core_clk) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata <= sfic_pkg::READ_ZERO;
        end else if (!waitrequest) begin
            waitrequest <= 1'b1;
        end else if (read || write) begin
            waitrequest <= 1'b0;
            readdata <= read ? rd_mux : readdata;
        end
    end
endmodule

// ===== test/sfic_front.sv
// Behavioural comparator and logic pin model facing the core
`timescale 1ns/1ps
// ==========================================================
// Front end model
module sfic_front (
    // Clock
    input wire logic core_clk,
    // Requests from the bench, pull-down enables from the core
    input wire logic [9:0][7:0] lvl_req,
    input wire logic [4:0] pin_req,
    input wire logic [4:0] pin_drv,
    input wire logic [4:0] pull_down_en,
    // Towards the core
    output logic [9:0][7:0] level,
    output logic [4:0] dual_function_input
);
    logic [9:0][7:0] lvl_q = '0;
    logic wander = 1'b0;
    // Comparator codes settle one cycle after a request
    always_ff @(posedge core_clk) begin
        lvl_q <= lvl_req;
        wander <= ~wander;
    end
    assign level = lvl_q;
    // A released pin sinks only with the pull-down on, else it wanders
    always_comb begin
        for (int j = 0; j < 5; j++) begin
            dual_function_input[j] = pin_drv[j] ? pin_req[j]
                : (pull_down_en[j] ? 1'b0 : wander);
        end
    end
endmodule

// ===== test/sfic_core_monitor.sv
// Port checker for the fault conditioning core
`timescale 1ns/1ps
// ==========================================================
// Checker
module sfic_core_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register bus
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Conditioned outputs
    input wire logic [9:0] fault,
    input wire logic warning_any,
    input wire logic [4:0] digital_out,
    input wire logic [4:0] pull_down_en
);
    logic [4:0] dig_sh;
    logic [4:0] pd_sh;
    logic [12:0] quiet;
    wire acc = write && !waitrequest && address[7:2] >= 6'h0a
        && address[7:2] < 6'h0f;
    wire [2:0] dj = 3'(address[7:2] - 6'h0a);
    wire settled = quiet == 13'h1fff;
    // Shadow of the dual modes; timer outlasts the longest filter
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dig_sh <= '0;
            pd_sh <= '0;
            quiet <= '0;
        end else if (acc) begin
            dig_sh[dj] <= writedata[0];
            pd_sh[dj] <= writedata[2];
            quiet <= '0;
        end else if (!settled) begin
            quiet <= quiet + 13'h0001;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Assertions
    bus_answer_a: assert property ((read || write) && waitrequest
        |=> !waitrequest) else $error("request not answered next cycle");
    bus_single_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    bus_cause_a: assert property ($fell(waitrequest) |-> $past(read || write))
        else $error("answer without request");
    read_hold_a: assert property ($changed(readdata) |-> $fell(waitrequest)
        && $past(read)) else $error("readdata moved without read");
    reset_clear_a: assert property (disable iff (1'b0) rst |=> waitrequest
        && fault == '0 && digital_out == '0) else $error("reset not clean");
    pull_sel_a: assert property (settled
        |-> pull_down_en == (dig_sh & pd_sh)) else $error("pull-down wrong");
    analog_quiet_a: assert property (settled
        |-> (digital_out & ~dig_sh) == 5'h00) else $error("analog gave logic");
    dual_fault_a: assert property (settled
        |-> (fault[9:5] & dig_sh) == 5'h00) else $error("digital gave fault");
    warn_src_a: assert property (warning_any
        |-> $past(dig_sh) != 5'h00) else $error("warning with no secondary");
    cover property (read && !waitrequest);
    cover property ($rose(warning_any));
    cover property ($rose(digital_out[1]));
endmodule
bind sfic_core sfic_core_chk chk (.core_clk(core_clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .fault(fault),
    .warning_any(warning_any), .digital_out(digital_out),
    .pull_down_en(pull_down_en));

// ===== test/tb_sfic_core.sv
// Self-checking bench for the fault conditioning core
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
// ==========================================================
// Bench
module tb_sfic_core;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [9:0][7:0] lvl_req = '0;
    logic [9:0][7:0] level;
    logic [4:0] pin_req = '0;
    logic [4:0] pin_drv = '0;
    logic [4:0] dual_function_input;
    logic [4:0] digital_out;
    logic [4:0] pull_down_en;
    logic [9:0] fault;
    logic warning_any;
    logic [15:0] la;
    logic [15:0] lb;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] exp_q[$];
    logic [31:0] exp_v;
    int hy_ch[10] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1};
    logic [7:0] hy_lv[10] = '{8'h80, 8'h84, 8'h85, 8'h80, 8'h7f, 8'h90,
        8'h40, 8'h41, 8'h3d, 8'h3c};
    logic [1:0] hy_f[10] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0,
        2'h2, 2'h2, 2'h0};
    sfic_core dut (.core_clk(core_clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .level(level),
        .dual_function_input(dual_function_input), .fault(fault),
        .warning_any(warning_any), .digital_out(digital_out),
        .pull_down_en(pull_down_en));
    sfic_front front (.core_clk(core_clk), .lvl_req(lvl_req),
        .pin_req(pin_req), .pin_drv(pin_drv), .pull_down_en(pull_down_en),
        .level(level), .dual_function_input(dual_function_input));
    always #12.5 core_clk = ~core_clk;
    // Each completed read takes the oldest note off the queue
    always @(posedge core_clk) begin
        if (!rst && read && !waitrequest) begin
            // Pop once; the macro reads its expected argument twice
            exp_v = exp_q.pop_front();
            `CHK(readdata, exp_v)
        end
    end
    // Hang guard, well above the planned run length
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Bus cycles hold the request until waitrequest is seen low
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        address <= a;
        read <= 1'b1;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        @(posedge core_clk);
    endtask
    function automatic logic [31:0] cc(input logic [7:0] u, o,
            input logic [4:0] h, input logic [1:0] s, input logic [6:0] g);
        return {g, 2'h0, s, h, o, u};
    endfunction
    // Dip channel 2 to a random low code; lag is first cycle fault shows
    task automatic dip(input int len, output logic [15:0] lag);
        lag = '1;
        lvl_req[2] <= 8'($urandom_range(127));
        for (int k = 1; k < 300; k++) begin
            @(posedge core_clk);
            if (k == len) lvl_req[2] <= 8'hff;
            if (fault[2] === 1'b1 && lag == '1) lag = 16'(k);
        end
    endtask
    // Count cycles that the edge pulse stays high after a pin toggle
    task automatic edge_len(output logic [15:0] n);
        n = '0;
        pin_req[1] <= ~pin_req[1];
        repeat (100) begin
            @(posedge core_clk);
            if (digital_out[1] === 1'b1) n++;
        end
    endtask
    initial begin
        void'($urandom(56000));
        tick(10);
        rst <= 1'b0;
        tick(1);
        rd(8'h00, 32'h0);
        rd(8'h28, 32'h0);
        wr(8'h80, 32'hffffffff);
        rd(8'h80, 32'h0);
        wr(8'h18, 32'h0180_0000);
        rd(8'h18, 32'h0);
        wr(8'h04, cc(8'h12, 8'h34, 5'h1f, 2'h3, 7'h7f));
        rd(8'h04, cc(8'h12, 8'h34, 5'h1f, 2'h3, 7'h64));
        $display("test registers done");
        wr(8'h00, cc(8'h80, 8'h00, 5'h04, 2'h1, 7'h01));
        wr(8'h04, cc(8'h00, 8'h40, 5'h03, 2'h2, 7'h00));
        foreach (hy_lv[i]) begin
            lvl_req[hy_ch[i]] <= hy_lv[i];
            tick(60);
            rd(8'h40, {22'h0, 8'h00, hy_f[i]});
        end
        $display("test hysteresis done");
        lvl_req[2] <= 8'hff;
        wr(8'h08, cc(8'h80, 8'h00, 5'h00, 2'h1, 7'h01));
        tick(100);
        dip(30, la);
        `CHK(la, 16'hffff)
        dip(150, la);
        wr(8'h08, cc(8'h80, 8'h00, 5'h00, 2'h1, 7'h02));
        dip(79, lb);
        `CHK(lb, 16'hffff)
        dip(150, lb);
        `CHK(lb - la, 16'h0028)
        $display("test glitch done");
        wr(8'h28, 32'h5);
        tick(10);
        `CHK(pull_down_en, 5'h01)
        rd(8'h40, 32'h0);
        pin_drv <= 5'h03;
        pin_req[0] <= 1'b1;
        tick(10);
        rd(8'h40, 32'h0000_0400);
        wr(8'h14, cc(8'h00, 8'h00, 5'h00, 2'h0, 7'h01));
        pin_req[0] <= 1'b0;
        tick(20);
        // Read inside the short low pulse: the filter must still hold high
        rd(8'h40, 32'h0000_0400);
        pin_req[0] <= 1'b1;
        tick(60);
        rd(8'h40, 32'h0000_0400);
        pin_req[0] <= 1'b0;
        tick(60);
        rd(8'h40, 32'h0);
        wr(8'h2c, 32'h0000_000b);
        tick(20);
        edge_len(la);
        `CHK(la, 16'h0028)
        edge_len(la);
        `CHK(la, 16'h0028)
        $display("test digital done");
        wr(8'h30, 32'h5);
        wr(8'h1c, cc(8'h50, 8'h00, 5'h00, 2'h1, 7'h00));
        lvl_req[2] <= 8'h40;
        tick(150);
        rd(8'h40, 32'h0012_0004);
        lvl_req[2] <= 8'hff;
        tick(150);
        rd(8'h40, 32'h0);
        $display("test warning done");
        tick(8300);
        print_verdict();
    end
endmodule
